/* bench/pcil_assertions.sv */
// Port checker for the pin change block.
// Assumes pin changes reach the flags three edges after sampling.
`timescale 1ns/1ps
`include "pcil_cfg.svh"
module pcil_checker
   import pcil_pkg::*;
(
   input wire logic                    clk,      // System clock
   input wire logic                    rst_n,    // Sync reset
   input wire logic [23:0]             pinsIn,   // Pins
   input wire logic                    globalIe, // Global bit
   input wire logic [2:0]              svcAck,   // Acknowledge
   input wire pcil_pkg::pcil_bus_req_t busReq,   // Register port
   input wire logic [7:0]              rdData,   // Read data
   input wire pcil_pkg::pcil_irq_out_t irqOut,   // Requests, flags
   input wire logic                    irq       // Summary
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Stable pins exclude the set-wins case
   property p_set0; $rose(irqOut.flags[0]) |-> $past(pinsIn[7:0],3) != $past(pinsIn[7:0],4); endproperty
   a_set0: assert property (p_set0) else $error("group0 flag without change");
   property p_set1; $rose(irqOut.flags[1]) |-> $past(pinsIn[15:8],3) != $past(pinsIn[15:8],4); endproperty
   a_set1: assert property (p_set1) else $error("group1 flag without change");
   property p_set2; $rose(irqOut.flags[2]) |-> $past(pinsIn[23:16],3) != $past(pinsIn[23:16],4); endproperty
   a_set2: assert property (p_set2) else $error("group2 flag without change");
   property p_req; irqOut.req != 3'h0 |-> (irqOut.req & ~irqOut.flags) == 3'h0 && $past(globalIe); endproperty
   a_req: assert property (p_req) else $error("request without flag");
   property p_svc; (svcAck & irqOut.req) != 3'h0 && $past(pinsIn,2) == $past(pinsIn,3)
      |=> (irqOut.flags & $past(svcAck & irqOut.req)) == 3'h0; endproperty
   a_svc: assert property (p_svc) else $error("flag kept after entry");
   property p_w1c; busReq.wr && busReq.addr == `PCIL_OFF_FLAG && $past(pinsIn,2) == $past(pinsIn,3)
      |=> (irqOut.flags & $past(busReq.wdata[2:0])) == 3'h0; endproperty
   a_w1c: assert property (p_w1c) else $error("flag kept after write one");
   property p_rdf; busReq.rd && busReq.addr == `PCIL_OFF_FLAG |=> rdData == {5'h00, $past(irqOut.flags)}; endproperty
   a_rdf: assert property (p_rdf) else $error("flag read wrong");
   property p_rdz; !$past(busReq.rd) |-> rdData == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside read");
   c_ack: cover property (svcAck[1] && irqOut.req[1]);
   c_set: cover property ($rose(irqOut.flags[2]));
   c_irq: cover property ($rose(irq));
endmodule
bind pcil_top pcil_checker pcil_checker_inst (.clk(clk), .rst_n(rst_n), .pinsIn(pinsIn), .globalIe(globalIe),
   .svcAck(svcAck), .busReq(busReq), .rdData(rdData), .irqOut(irqOut), .irq(irq));

/* bench/pcil_far_model.sv */
// Far side: external pins and the processor taking vectors.
// Assumes the bench sets pin levels and allows acknowledges.
`timescale 1ns/1ps
module pcil_far_model
(
   input  wire logic        clk,     // System clock
   input  wire logic        rst_n,   // Sync reset, active low
   input  wire logic [23:0] pinsSet, // Levels the bench asks for
   input  wire logic        ackEn,   // Processor takes vectors
   input  wire logic [2:0]  req,     // Vector requests
   output logic      [23:0] pinsIn = 24'h000000, // Pin levels
   output logic      [2:0]  svcAck = 3'h0        // Routine entered
);
   // One-cycle pulse; holding ackEn low models a slow processor
   always @(posedge clk)
   begin
      pinsIn <= pinsSet;
      svcAck <= (rst_n && ackEn) ? (req & ~svcAck) : 3'h0;
   end
endmodule

/* bench/test_pin_change_interrupt_logic.sv */
// Self-checking bench for the pin change block.
// Assumes the far-side model drives pins and acknowledges.
`timescale 1ns/1ps
`include "pcil_cfg.svh"
module test_pin_change_interrupt_logic;
   import pcil_pkg::*;
   logic          clk, rst_n, gie, ackEn, irq;
   logic [23:0]   pinsSet, pinsIn;
   logic [2:0]    svcAck;
   logic [7:0]    rdData, m;
   pcil_bus_req_t busReq;
   pcil_irq_out_t irqOut;
   int            fails, compares, cyc, g, seed;
   pcil_top pcil_top_inst (.clk(clk), .rst_n(rst_n), .pinsIn(pinsIn), .globalIe(gie), .svcAck(svcAck),
      .busReq(busReq), .rdData(rdData), .irqOut(irqOut), .irq(irq));
   pcil_far_model pcil_far_model_inst (.clk(clk), .rst_n(rst_n), .pinsSet(pinsSet), .ackEn(ackEn),
      .req(irqOut.req), .pinsIn(pinsIn), .svcAck(svcAck));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 chk("rdData", e, rdData);
   endtask
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Ceiling well above the fewer than two hundred cycles needed
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end
   initial
   begin
      rst_n = 1'b0; gie = 1'b0; ackEn = 1'b0; pinsSet = 24'h000000; busReq = '0;
      fails = 0; compares = 0; seed = 32'h9F96CC99;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`PCIL_OFF_FLAG, 8'h00);
      rd(`PCIL_OFF_CTRL, 8'h00);
      for (g = 0; g < 3; g++)
         rd(`PCIL_OFF_MASK0 + 8'(g), 8'h00);
      rd(8'h55, 8'h00);
      // Random pin activity while groups are still disabled
      pinsSet <= 24'($random(seed));
      wr(`PCIL_OFF_MASK0, 8'hFF);
      repeat (6) @(posedge clk);
      rd(`PCIL_OFF_FLAG, 8'h00);
      wr(`PCIL_OFF_MASK0, 8'h00);
      wr(`PCIL_OFF_CTRL, 8'h07);
      rd(`PCIL_OFF_CTRL, 8'h07);
      $display("test reset and gating done");
      for (g = 0; g < 3; g++)
      begin
         m = 8'h01 << ($unsigned($random(seed)) % 8);
         wr(`PCIL_OFF_MASK0 + 8'(g), m);
         rd(`PCIL_OFF_MASK0 + 8'(g), m);
         pinsSet <= pinsSet ^ ({16'h0000, ~m} << (8 * g));
         repeat (6) @(posedge clk);
         rd(`PCIL_OFF_FLAG, 8'h00);
         pinsSet <= pinsSet ^ ({16'h0000, m} << (8 * g));
         repeat (6) @(posedge clk);
         rd(`PCIL_OFF_FLAG, 8'h01 << g);
         chk("req", 8'h00, {5'h00, irqOut.req});
         wr(`PCIL_OFF_FLAG, 8'h00);
         rd(`PCIL_OFF_FLAG, 8'h01 << g);
         wr(`PCIL_OFF_FLAG, 8'hFF);
         rd(`PCIL_OFF_FLAG, 8'h00);
         // Change lands in the clearing cycle: set must win
         pinsSet <= pinsSet ^ ({16'h0000, m} << (8 * g));
         repeat (2) @(posedge clk);
         wr(`PCIL_OFF_FLAG, 8'h01 << g);
         rd(`PCIL_OFF_FLAG, 8'h01 << g);
         wr(`PCIL_OFF_FLAG, 8'hFF);
         wr(`PCIL_OFF_MASK0 + 8'(g), 8'h00);
      end
      for (g = 0; g < 3; g++)
         rd(`PCIL_OFF_PINS0 + 8'(g), pinsSet[8 * g +: 8]);
      $display("test group flags done");
      wr(`PCIL_OFF_MASK1, 8'hFF);
      wr(`PCIL_OFF_IRQMASK, 8'h02);
      gie <= 1'b1;
      pinsSet <= pinsSet ^ 24'h000100;
      repeat (6) @(posedge clk);
      chk("req", 8'h02, {5'h00, irqOut.req});
      chk("irq", 8'h01, {7'h00, irq});
      chk("flags", 8'h02, {5'h00, irqOut.flags});
      wr(`PCIL_OFF_IRQSTAT, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      ackEn <= 1'b1;
      repeat (4) @(posedge clk);
      chk("req", 8'h00, {5'h00, irqOut.req});
      rd(`PCIL_OFF_FLAG, 8'h00);
      rd(`PCIL_OFF_IRQMASK, 8'h02);
      rd(`PCIL_OFF_IRQSTAT, 8'h05);
      $display("test vector and service done");
      wrap_up();
   end
endmodule

/* inc/pcil_cfg.svh */
// Offsets, group sizes, reset values for the pin change interrupt block.
// Included by package users; definitions only.
`ifndef PCIL_CFG_SVH
`define PCIL_CFG_SVH
`define PCIL_OFF_FLAG      8'h1B
`define PCIL_OFF_CTRL      8'h68
`define PCIL_OFF_MASK0     8'h6B
`define PCIL_OFF_MASK1     8'h6C
`define PCIL_OFF_MASK2     8'h6D
`define PCIL_OFF_IRQSTAT   8'h70
`define PCIL_OFF_IRQMASK   8'h71
`define PCIL_OFF_PINS0     8'h72
`define PCIL_OFF_PINS1     8'h73
`define PCIL_OFF_PINS2     8'h74
`define PCIL_RST_BYTE      8'h00
`define PCIL_RST_GRP       3'h0
`define PCIL_RST_PINS      24'h000000
`define PCIL_GROUPS        3
`define PCIL_PINS_PER_GRP  8
`endif

/* inc/pcil_pkg.sv */
// Types for the pin change interrupt block.
// Constants live in pcil_cfg.svh.
package pcil_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pcil_bus_req_t;

   typedef struct packed {
      logic [2:0] req;
      logic [2:0] flags;
   } pcil_irq_out_t;

   typedef enum logic [1:0] {
      PCIL_IDLE,
      PCIL_ACK
   } pcil_ack_t;
endpackage

/* rtl/pcil_detect.sv */
// Per-pin change detector: compares consecutive synchronised samples.
// Inputs come from the synchroniser on the same clock.
`timescale 1ns/1ps
`include "pcil_cfg.svh"
module pcil_detect
(
   input  wire logic        clk,      // System clock
   input  wire logic        rst_n,    // Sync reset, active low
   input  wire logic [23:0] pinsSync, // Synchronised pins
   input  wire logic [23:0] pinMask,  // Per-pin masks, all groups
   output logic      [2:0]  grpHit,   // Change seen per group, one cycle
   output logic      [23:0] pinsLast  // Previous sample
);
   typedef struct packed {
      logic [23:0] last;
      logic        primed;
   } pcil_det_st_t;

   pcil_det_st_t st_ff;
   pcil_det_st_t nxt_st;
   logic [23:0]  diff;

   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.last   = pinsSync;
      nxt_st.primed = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // First sample after reset is not a change
   assign diff = st_ff.primed ? ((pinsSync ^ st_ff.last) & pinMask) : 24'h000000; // RULE13 RULE11

   genvar g;
   generate
      for (g = 0; g < `PCIL_GROUPS; g++)
      begin : gGrp
         assign grpHit[g] = |diff[g*8 +: 8];
      end
   endgenerate

   assign pinsLast = st_ff.last;
endmodule

/* rtl/pcil_sync.sv */
// Two-stage synchroniser for the external pin levels.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module pcil_sync
(
   input  wire logic        clk,      // System clock
   input  wire logic        rst_n,    // Sync reset, active low
   input  wire logic [23:0] pinsIn,   // Raw pins
   output logic      [23:0] pinsSync  // Synchronised pins
);
   typedef struct packed {
      logic [23:0] s1;
      logic [23:0] s2;
   } pcil_sync_st_t;

   pcil_sync_st_t st_ff;
   pcil_sync_st_t nxt_st;

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = pinsIn;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign pinsSync = st_ff.s2;
endmodule

/* rtl/pcil_top.sv */
// Pin change interrupt logic: 24 pins in three groups of eight, per-pin
// masks, group enables, sticky group flags and vector requests.
// Assumes a single-cycle register port and a CPU that pulses svcAck on
// entry to a group's service routine.
//
// How it works
// RULE1: Unmasked change on pins 23..16 sets group-two flag, bit 2.
// RULE2: Unmasked change on pins 15..8 sets group-one flag, bit 1.
// RULE3: Unmasked change on pins 7..0 sets group-zero flag, bit 0.
// RULE4: Flag set with group enable and global bit requests that group's vector.
// RULE5: Entering a group's service routine clears that group's flag.
// RULE6: Writing one clears a flag bit; writing zero leaves it.
// RULE7: Flag register is 8 bits, resets zero, bits 7..3 read zero.
// RULE8: Group-two mask bit enables detection on its pin when group-two enabled.
// RULE9: Group-one mask bit enables detection on its pin when group-one enabled.
// RULE10: Group-zero mask bit enables detection on its pin when group-zero enabled.
// RULE11: Cleared mask bit never lets its pin set the group flag.
// RULE12: Enable bits sit in control bits 2..0, gated by the global bit.
// RULE13: Changes found by comparing consecutive synchronised samples.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pcil_cfg.svh"
module pcil_top
(
   input  wire logic                  clk,        // System clock, 100 MHz
   input  wire logic                  rst_n,      // Sync reset, active low
   input  wire logic [23:0]           pinsIn,     // External pins, async
   input  wire logic                  globalIe,   // Processor global interrupt bit
   input  wire logic [2:0]            svcAck,     // Service routine entered, per group
   input  wire pcil_pkg::pcil_bus_req_t busReq,   // Register port request
   output logic      [7:0]            rdData,     // Read data, cycle after read
   output pcil_pkg::pcil_irq_out_t    irqOut,     // Vector requests and flags
   output logic                       irq         // Summary interrupt, level
);
   import pcil_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]    mask0;
      logic [7:0]    mask1;
      logic [7:0]    mask2;
      logic [2:0]    ctrl;
      logic [2:0]    flags;
      logic [2:0]    irqStat;
      logic [2:0]    irqMask;
      logic [7:0]    rdData;
      pcil_irq_out_t irqOut;
      logic          irq;
   } pcil_top_st_t;

   pcil_top_st_t st_ff;
   pcil_top_st_t nxt_st;

   logic [23:0] pinsSync;
   logic [23:0] pinsLast;
   logic [23:0] pinMask;
   logic [2:0]  grpHit;
   logic [2:0]  grpEn;

   ////////////////////////////////////////////////////////////////////////
   // Pin path

   pcil_sync uSync
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .pinsIn   (pinsIn),
      .pinsSync (pinsSync)
   );

   // Mask bit counts only while its group is enabled
   genvar g;
   generate
      for (g = 0; g < `PCIL_GROUPS; g++)
      begin : gEn
         assign grpEn[g] = st_ff.ctrl[g];
      end
   endgenerate

   assign pinMask = {st_ff.mask2 & {8{grpEn[2]}},                // RULE8
                     st_ff.mask1 & {8{grpEn[1]}},                // RULE9
                     st_ff.mask0 & {8{grpEn[0]}}};               // RULE10

   pcil_detect uDetect
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .pinsSync (pinsSync),
      .pinMask  (pinMask),
      .grpHit   (grpHit),
      .pinsLast (pinsLast)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic [2:0] wrClr;
      logic [2:0] hwClr;
      logic [2:0] statClr;
      logic [2:0] flagsNext;
      logic       wrHit;
      wrClr     = 3'h0;
      hwClr     = 3'h0;
      statClr   = 3'h0;
      flagsNext = 3'h0;
      wrHit     = busReq.wr;
      nxt_st    = st_ff;

      if (wrHit)
      begin
         case (busReq.addr)
            `PCIL_OFF_MASK0:   nxt_st.mask0   = busReq.wdata;
            `PCIL_OFF_MASK1:   nxt_st.mask1   = busReq.wdata;
            `PCIL_OFF_MASK2:   nxt_st.mask2   = busReq.wdata;
            `PCIL_OFF_CTRL:    nxt_st.ctrl    = busReq.wdata[2:0];  // RULE12
            `PCIL_OFF_FLAG:    wrClr          = busReq.wdata[2:0];  // RULE6
            `PCIL_OFF_IRQSTAT: statClr        = busReq.wdata[2:0];
            `PCIL_OFF_IRQMASK: nxt_st.irqMask = busReq.wdata[2:0];
            default:           ;
         endcase
      end

      // Acknowledge clears only a flag being serviced
      hwClr = svcAck & st_ff.irqOut.req;                            // RULE5

      // Set beats clear so a change in the clearing cycle is kept
      flagsNext    = (st_ff.flags & ~(wrClr | hwClr)) | grpHit;     // RULE1 RULE2 RULE3
      nxt_st.flags = flagsNext;

      nxt_st.irqStat = (st_ff.irqStat & ~statClr) | grpHit;

      // Vector request needs flag, group enable and global bit
      nxt_st.irqOut.flags = flagsNext;
      nxt_st.irqOut.req   = flagsNext & nxt_st.ctrl & {3{globalIe}}; // RULE4 RULE12
      nxt_st.irq          = |(nxt_st.irqStat & nxt_st.irqMask);

      nxt_st.rdData = 8'h00;
      if (busReq.rd)
      begin
         case (busReq.addr)
            `PCIL_OFF_FLAG:    nxt_st.rdData = {5'h00, st_ff.flags};  // RULE7
            `PCIL_OFF_CTRL:    nxt_st.rdData = {5'h00, st_ff.ctrl};
            `PCIL_OFF_MASK0:   nxt_st.rdData = st_ff.mask0;
            `PCIL_OFF_MASK1:   nxt_st.rdData = st_ff.mask1;
            `PCIL_OFF_MASK2:   nxt_st.rdData = st_ff.mask2;
            `PCIL_OFF_IRQSTAT: nxt_st.rdData = {5'h00, st_ff.irqStat};
            `PCIL_OFF_IRQMASK: nxt_st.rdData = {5'h00, st_ff.irqMask};
            `PCIL_OFF_PINS0:   nxt_st.rdData = pinsLast[7:0];
            `PCIL_OFF_PINS1:   nxt_st.rdData = pinsLast[15:8];
            `PCIL_OFF_PINS2:   nxt_st.rdData = pinsLast[23:16];
            default:           nxt_st.rdData = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;                                               // RULE7
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign rdData = st_ff.rdData;
   assign irqOut = st_ff.irqOut;
   assign irq    = st_ff.irq;
endmodule
